// File: core/sipr_pkg.sv
// Notes on behaviour
// [R1] Config bit 0: level or edge input trigger.
// [R2] Config bit 1: pin active low or high.
// [R3] Config bit 2: push-pull or open-drain drive.
// [R4] Config bit 3: pin driven only when set.
// [R5] Config bit 4: input enable; bits 7-5 reserved.
// [R6] Second pin config at 0x54, same layout.
// [R7] Hold-mode bit 0: non-latched or latched interrupts.
// [R8] First pin feature routing: motion, still, error.
// [R9] Second pin feature routing: motion, still, error.
// [R10] Hardware routing bits 0-2 feed first pin.
// [R11] Hardware routing bits 4-6 feed second pin.
// [R12] Startup register 0x59 resets 0x90, host-written.
// [R13] Pin asserts on OR of routed sources.
// [R14] Latched events hold until status is read.
package sipr_pkg;

  localparam logic [7:0] OFF_PIN_A_CFG = 8'h53;
  localparam logic [7:0] OFF_PIN_B_CFG = 8'h54;
  localparam logic [7:0] OFF_HOLD      = 8'h55;
  localparam logic [7:0] OFF_MAP_A     = 8'h56;
  localparam logic [7:0] OFF_MAP_B     = 8'h57;
  localparam logic [7:0] OFF_HW_MAP    = 8'h58;
  localparam logic [7:0] OFF_STARTUP   = 8'h59;
  localparam logic [7:0] OFF_STATUS    = 8'h5a;
  localparam logic [7:0] OFF_MASK      = 8'h5b;

  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_STARTUP = 8'h90;

  localparam logic [7:0] CFG_WMASK  = 8'h1f;
  localparam logic [7:0] HOLD_WMASK = 8'h01;
  localparam logic [7:0] MAP_WMASK  = 8'he0;
  localparam logic [7:0] HW_WMASK   = 8'h77;

  localparam int CFG_EDGE  = 0;
  localparam int CFG_LVL   = 1;
  localparam int CFG_OD    = 2;
  localparam int CFG_OEN   = 3;
  localparam int HOLD_BIT  = 0;
  localparam int MAP_ANY   = 5;
  localparam int MAP_STILL = 6;
  localparam int MAP_ERR   = 7;
  localparam int HW_FULL   = 0;
  localparam int HW_LEVEL  = 1;
  localparam int HW_READY  = 2;
  localparam int HW_B_BASE = 4;

  localparam int EV_ANY   = 0;
  localparam int EV_STILL = 1;
  localparam int EV_ERR   = 2;
  localparam int EV_FULL  = 3;
  localparam int EV_LEVEL = 4;
  localparam int EV_READY = 5;
  localparam int EV_N     = 6;

  typedef struct packed {
    logic ready;
    logic level;
    logic full;
    logic err;
    logic still;
    logic any;
  } sipr_events_t;

  typedef struct packed {
    logic in_en;
    logic out_en;
    logic drive_style_select;
    logic active_high;
    logic edge_trig;
  } sipr_pin_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sipr_pin_drive_t;

  typedef struct packed {
    logic            sync1;
    logic            sync2;
    logic            prev;
    logic            trig;
    sipr_pin_drive_t drv;
  } sipr_pin_state_t;

  typedef struct packed {
    logic [7:0]      cfg_a;
    logic [7:0]      cfg_b;
    logic [7:0]      hold;
    logic [7:0]      map_a;
    logic [7:0]      map_b;
    logic [7:0]      hw_map;
    logic [7:0]      startup;
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] mask;
    logic [7:0]      rdata;
    logic            start_wr;
  } sipr_core_state_t;

endpackage

// File: core/sipr_pin.sv
`timescale 1ns/1ns
module sipr_pin (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  input  wire sipr_pkg::sipr_pin_cfg_t   i_cfg,
  input  wire logic                      i_assert,
  input  wire logic                      i_pin,
  output sipr_pkg::sipr_pin_drive_t      o_drive,
  output logic                           o_trigger
);

  sipr_pkg::sipr_pin_state_t r_reg;
  sipr_pkg::sipr_pin_state_t r_next;
  logic                      act_now;
  logic                      act_prev;
  logic                      lvl;

  always_comb begin
    r_next       = r_reg;
    r_next.sync1 = i_pin;
    r_next.sync2 = r_reg.sync1;
    r_next.prev  = r_reg.sync2;
    act_now  = i_cfg.active_high ? r_reg.sync2 : ~r_reg.sync2;
    act_prev = i_cfg.active_high ? r_reg.prev : ~r_reg.prev;
    // The edge form fires once per entry into the active level.
    r_next.trig = i_cfg.in_en & // R5
                  (i_cfg.edge_trig ? (act_now & ~act_prev) : act_now); // R1
    lvl = i_cfg.active_high ? i_assert : ~i_assert; // R2
    if (i_cfg.drive_style_select) begin // R3
      // Open drain only pulls low; the idle level comes from the pull-up.
      r_next.drv.o  = 1'b0;
      r_next.drv.oe = i_cfg.out_en & ~lvl; // R4
    end else begin
      r_next.drv.o  = lvl;
      r_next.drv.oe = i_cfg.out_en; // R4
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      // The chain starts at the pulled-up idle level, so that the release
      // of reset shows no false edge.
      r_reg       <= '0;
      r_reg.sync1 <= 1'b1;
      r_reg.sync2 <= 1'b1;
      r_reg.prev  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_drive   = r_reg.drv;
  assign o_trigger = r_reg.trig;

  property p_edge_needs_change;
    @(posedge i_clock) disable iff (i_rst)
    (i_cfg.in_en && i_cfg.edge_trig && r_reg.sync2 == r_reg.prev)
      |=> !o_trigger;
  endproperty
  a_edge_needs_change: assert property (p_edge_needs_change) // R1
    else $error("edge trigger fired without a pin change");

  property p_polarity;
    @(posedge i_clock) disable iff (i_rst)
    (!i_cfg.drive_style_select && i_assert)
      |=> (o_drive.o == $past(i_cfg.active_high));
  endproperty
  a_polarity: assert property (p_polarity) // R2
    else $error("asserted pin level does not follow polarity");

  property p_open_drain;
    @(posedge i_clock) disable iff (i_rst)
    i_cfg.drive_style_select |=> (!o_drive.o ##1 1'b1);
  endproperty
  a_open_drain: assert property (p_open_drain) // R3
    else $error("open drain pin drove a high level");

  property p_out_gate;
    @(posedge i_clock) disable iff (i_rst)
    !i_cfg.out_en |=> !o_drive.oe;
  endproperty
  a_out_gate: assert property (p_out_gate) // R4
    else $error("pin driven while output disabled");

  property p_in_gate;
    @(posedge i_clock) disable iff (i_rst)
    !i_cfg.in_en |=> !o_trigger;
  endproperty
  a_in_gate: assert property (p_in_gate) // R5
    else $error("input trigger while input disabled");

endmodule

// File: core/sipr_core.sv
`timescale 1ns/1ns
module sipr_core (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  input  wire logic [7:0]                i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic [7:0]                     o_rdata,
  input  wire sipr_pkg::sipr_events_t    i_events,
  input  wire logic                      i_pin_a,
  input  wire logic                      i_pin_b,
  output sipr_pkg::sipr_pin_drive_t      o_pin_a,
  output sipr_pkg::sipr_pin_drive_t      o_pin_b,
  output logic                           o_pin_a_trig,
  output logic                           o_pin_b_trig,
  output logic                           o_irq,
  output logic [7:0]                     o_startup_cmd,
  output logic                           o_startup_wr
);

  sipr_pkg::sipr_core_state_t   r_reg;
  sipr_pkg::sipr_core_state_t   r_next;
  logic [sipr_pkg::EV_N-1:0]    ev_live;
  logic [sipr_pkg::EV_N-1:0]    ev_src;
  logic [sipr_pkg::EV_N-1:0]    clr;
  logic                         status_rd;
  logic                         asrt_a;
  logic                         asrt_b;

  // One routing decode serves both pins.
  function automatic logic route(
    input logic [sipr_pkg::EV_N-1:0] ev,
    input logic [7:0]                feat,
    input logic [2:0]                hw
  );
    route = (ev[sipr_pkg::EV_ANY]   & feat[sipr_pkg::MAP_ANY])   |
            (ev[sipr_pkg::EV_STILL] & feat[sipr_pkg::MAP_STILL]) |
            (ev[sipr_pkg::EV_ERR]   & feat[sipr_pkg::MAP_ERR])   |
            (ev[sipr_pkg::EV_FULL]  & hw[sipr_pkg::HW_FULL])     |
            (ev[sipr_pkg::EV_LEVEL] & hw[sipr_pkg::HW_LEVEL])    |
            (ev[sipr_pkg::EV_READY] & hw[sipr_pkg::HW_READY]);
  endfunction

  assign ev_live   = i_events;
  assign status_rd = i_rd && (i_addr == sipr_pkg::OFF_STATUS);

  // Latched mode drives the pins from the sticky status, otherwise from
  // the live conditions. The latched path lags the live one by a cycle.
  always_comb begin
    if (r_reg.hold[sipr_pkg::HOLD_BIT]) begin // R7
      ev_src = r_reg.status; // R14
    end else begin
      ev_src = ev_live; // R14
    end
    asrt_a = route(ev_src, r_reg.map_a, // R8
                   r_reg.hw_map[2:0]); // R10 R13
    asrt_b = route(ev_src, r_reg.map_b, // R9
                   r_reg.hw_map[sipr_pkg::HW_B_BASE +: 3]); // R11 R13
  end

  always_comb begin
    r_next          = r_reg;
    r_next.rdata    = 8'h00;
    r_next.start_wr = 1'b0;
    clr             = '0;
    if (i_wr) begin
      case (i_addr)
        sipr_pkg::OFF_PIN_A_CFG: begin
          r_next.cfg_a = i_wdata & sipr_pkg::CFG_WMASK; // R5
        end
        sipr_pkg::OFF_PIN_B_CFG: begin
          r_next.cfg_b = i_wdata & sipr_pkg::CFG_WMASK; // R6
        end
        sipr_pkg::OFF_HOLD: begin
          r_next.hold = i_wdata & sipr_pkg::HOLD_WMASK; // R7
        end
        sipr_pkg::OFF_MAP_A: begin
          r_next.map_a = i_wdata & sipr_pkg::MAP_WMASK; // R8
        end
        sipr_pkg::OFF_MAP_B: begin
          r_next.map_b = i_wdata & sipr_pkg::MAP_WMASK; // R9
        end
        sipr_pkg::OFF_HW_MAP: begin
          r_next.hw_map = i_wdata & sipr_pkg::HW_WMASK; // R11
        end
        sipr_pkg::OFF_STARTUP: begin
          r_next.startup  = i_wdata; // R12
          r_next.start_wr = 1'b1; // R12
        end
        sipr_pkg::OFF_MASK: begin
          r_next.mask = i_wdata[sipr_pkg::EV_N-1:0];
        end
        default: begin
          r_next.start_wr = 1'b0;
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        sipr_pkg::OFF_PIN_A_CFG: r_next.rdata = r_reg.cfg_a;
        sipr_pkg::OFF_PIN_B_CFG: r_next.rdata = r_reg.cfg_b;
        sipr_pkg::OFF_HOLD:      r_next.rdata = r_reg.hold;
        sipr_pkg::OFF_MAP_A:     r_next.rdata = r_reg.map_a;
        sipr_pkg::OFF_MAP_B:     r_next.rdata = r_reg.map_b;
        sipr_pkg::OFF_HW_MAP:    r_next.rdata = r_reg.hw_map;
        sipr_pkg::OFF_STARTUP:   r_next.rdata = r_reg.startup;
        sipr_pkg::OFF_STATUS: begin
          r_next.rdata = {2'b00, r_reg.status};
          clr          = r_reg.status; // R14
        end
        sipr_pkg::OFF_MASK:      r_next.rdata = {2'b00, r_reg.mask};
        default:                 r_next.rdata = 8'h00;
      endcase
    end
    // A new event in the clearing cycle survives: set wins over clear.
    r_next.status = (r_reg.status & ~clr) | ev_live; // R14
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_reg         <= '0;
      r_reg.startup <= sipr_pkg::RST_STARTUP; // R12
    end else begin
      r_reg <= r_next;
    end
  end

  sipr_pin u_pin_a (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_cfg     (sipr_pkg::sipr_pin_cfg_t'(r_reg.cfg_a[4:0])),
    .i_assert  (asrt_a),
    .i_pin     (i_pin_a),
    .o_drive   (o_pin_a),
    .o_trigger (o_pin_a_trig)
  );

  sipr_pin u_pin_b (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_cfg     (sipr_pkg::sipr_pin_cfg_t'(r_reg.cfg_b[4:0])), // R6
    .i_assert  (asrt_b),
    .i_pin     (i_pin_b),
    .o_drive   (o_pin_b),
    .o_trigger (o_pin_b_trig)
  );

  assign o_rdata       = r_reg.rdata;
  assign o_irq         = |(r_reg.status & r_reg.mask);
  assign o_startup_cmd = r_reg.startup;
  assign o_startup_wr  = r_reg.start_wr;

  property p_pin_b_cfg_write;
    @(posedge i_clock) disable iff (i_rst)
    (i_wr && i_addr == sipr_pkg::OFF_PIN_B_CFG)
      |=> (r_reg.cfg_b == ($past(i_wdata) & 8'h1f));
  endproperty
  a_pin_b_cfg_write: assert property (p_pin_b_cfg_write) // R6
    else $error("second pin config not stored with its layout");

  property p_live_still;
    @(posedge i_clock) disable iff (i_rst)
    (!r_reg.hold[0] && r_reg.map_a[6] && i_events.still) |-> asrt_a;
  endproperty
  a_live_still: assert property (p_live_still) // R7
    else $error("non-latched still event not on first pin");

  property p_map_a_any;
    @(posedge i_clock) disable iff (i_rst)
    (!r_reg.hold[0] && i_events.any && r_reg.map_a[5] &&
     r_reg.cfg_a[3] && !r_reg.cfg_a[2] && r_reg.cfg_a[1] && !i_wr)
      |=> o_pin_a.o && o_pin_a.oe;
  endproperty
  a_map_a_any: assert property (p_map_a_any) // R8
    else $error("motion event routed to first pin not driven");

  property p_map_b_err;
    @(posedge i_clock) disable iff (i_rst)
    (!r_reg.hold[0] && r_reg.map_b[7] && i_events.err) |-> asrt_b;
  endproperty
  a_map_b_err: assert property (p_map_b_err) // R9
    else $error("error event routed to second pin not asserted");

  property p_hw_a_ready;
    @(posedge i_clock) disable iff (i_rst)
    (!r_reg.hold[0] && r_reg.hw_map[2] && i_events.ready) |-> asrt_a;
  endproperty
  a_hw_a_ready: assert property (p_hw_a_ready) // R10
    else $error("ready event routed to first pin not asserted");

  property p_hw_b_full;
    @(posedge i_clock) disable iff (i_rst)
    (!r_reg.hold[0] && r_reg.hw_map[4] && i_events.full &&
     r_reg.map_a == 8'h00 && r_reg.hw_map[2:0] == 3'h0) |-> asrt_b && !asrt_a;
  endproperty
  a_hw_b_full: assert property (p_hw_b_full) // R11
    else $error("full event routing to second pin wrong");

  property p_startup_write;
    @(posedge i_clock) disable iff (i_rst)
    (i_wr && i_addr == sipr_pkg::OFF_STARTUP)
      |=> o_startup_wr && (o_startup_cmd == $past(i_wdata))
      ##1 (!o_startup_wr ||
           $past(i_wr && i_addr == sipr_pkg::OFF_STARTUP));
  endproperty
  a_startup_write: assert property (p_startup_write) // R12
    else $error("startup command write not seen as one pulse");

  property p_or_quiet;
    @(posedge i_clock) disable iff (i_rst)
    (!asrt_a && r_reg.cfg_a[3] && !r_reg.cfg_a[2] && !r_reg.cfg_a[1] && !i_wr)
      |=> o_pin_a.o;
  endproperty
  a_or_quiet: assert property (p_or_quiet) // R13
    else $error("active low pin asserted with no routed source");

  property p_latched_hold;
    @(posedge i_clock) disable iff (i_rst)
    (r_reg.hold[0] && r_reg.status[0] && r_reg.map_b[5] &&
     !status_rd && !i_wr) |=> asrt_b;
  endproperty
  a_latched_hold: assert property (p_latched_hold) // R14
    else $error("latched event dropped before status read");

  property p_read_clears;
    @(posedge i_clock) disable iff (i_rst)
    (status_rd && !i_events.any && r_reg.status[0]) |=> !r_reg.status[0];
  endproperty
  a_read_clears: assert property (p_read_clears) // R14
    else $error("status read did not clear an idle event");

endmodule

// File: test/sipr_host_model.sv
`timescale 1ns/1ns
// Host side of both interrupt wires. The lines carry a pull-up, so a wire
// that nobody drives reads high rather than a stale value.
module sipr_host_model (
  input  wire logic                      i_host_en_a,
  input  wire logic                      i_host_lvl_a,
  input  wire logic                      i_host_en_b,
  input  wire logic                      i_host_lvl_b,
  input  wire sipr_pkg::sipr_pin_drive_t i_drv_a,
  input  wire sipr_pkg::sipr_pin_drive_t i_drv_b,
  output logic                           o_wire_a,
  output logic                           o_wire_b
);
  // The device wins while it drives; the host only drives an idle wire.
  assign o_wire_a = i_drv_a.oe ? i_drv_a.o
                  : (i_host_en_a ? i_host_lvl_a : 1'b1);
  assign o_wire_b = i_drv_b.oe ? i_drv_b.o
                  : (i_host_en_b ? i_host_lvl_b : 1'b1);
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                      i_clock = 1'b0;
  logic                      i_rst   = 1'b1;
  logic [7:0]                addr    = 8'h00;
  logic [7:0]                wdata   = 8'h00;
  logic                      wr      = 1'b0;
  logic                      rd      = 1'b0;
  sipr_pkg::sipr_events_t    ev      = '0;
  logic                      hen_a   = 1'b0;
  logic                      hlvl_a  = 1'b0;
  logic                      hen_b   = 1'b0;
  logic                      hlvl_b  = 1'b0;
  logic [7:0]                rdata;
  logic [7:0]                scmd;
  logic                      swr;
  logic                      trig_a;
  logic                      trig_b;
  logic                      irq;
  logic                      wire_a;
  logic                      wire_b;
  sipr_pkg::sipr_pin_drive_t drv_a;
  sipr_pkg::sipr_pin_drive_t drv_b;
  int                        err_count = 0;
  int                        checks    = 0;
  int                        cycles    = 0;
  logic [7:0]                wmask [7] = '{8'h1f, 8'h1f, 8'h01, 8'he0,
                                           8'he0, 8'h77, 8'hff};

  always #10 i_clock = ~i_clock;

  sipr_core dut_u (
    .i_clock       (i_clock),
    .i_rst         (i_rst),
    .i_addr        (addr),
    .i_wdata       (wdata),
    .i_wr          (wr),
    .i_rd          (rd),
    .o_rdata       (rdata),
    .i_events      (ev),
    .i_pin_a       (wire_a),
    .i_pin_b       (wire_b),
    .o_pin_a       (drv_a),
    .o_pin_b       (drv_b),
    .o_pin_a_trig  (trig_a),
    .o_pin_b_trig  (trig_b),
    .o_irq         (irq),
    .o_startup_cmd (scmd),
    .o_startup_wr  (swr)
  );

  sipr_host_model host_u (
    .i_host_en_a  (hen_a),
    .i_host_lvl_a (hlvl_a),
    .i_host_en_b  (hen_b),
    .i_host_lvl_b (hlvl_b),
    .i_drv_a      (drv_a),
    .i_drv_b      (drv_b),
    .o_wire_a     (wire_a),
    .o_wire_b     (wire_b)
  );

  task automatic complete_run();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clock);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clock);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic set_ev(input logic [5:0] v);
    @(posedge i_clock);
    ev <= v;
  endtask

  // A hang would otherwise never reach the verdict.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    chk(scmd, 8'h90);
    chk({6'h00, drv_a}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'h53 + 8'(i), (i == 6) ? 8'h90 : 8'h00);
    end
    rd_chk(8'h60, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'h53 + 8'(i), 8'hff);
      rd_chk(8'h53 + 8'(i), wmask[i]);
      wr_reg(8'h53 + 8'(i), 8'h00);
    end
    wr_reg(8'h59, 8'h5a);
    #1;
    chk({7'h00, swr}, 8'h01);
    chk(scmd, 8'h5a);
    tick(1);
    chk({7'h00, swr}, 8'h00);
    wr_reg(8'h53, 8'h0a);
    wr_reg(8'h54, 8'h0a);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 6; k++) begin
        wr_reg(8'h56, 8'h00);
        wr_reg(8'h57, 8'h00);
        wr_reg(8'h58, 8'h00);
        wr_reg((k < 3) ? 8'h56 + 8'(p) : 8'h58,
               8'h01 << ((k < 3) ? k + 5 : k - 3 + 4 * p));
        set_ev(6'h01 << k);
        tick(1);
        chk({6'h00, drv_a}, (p == 0) ? 8'h03 : 8'h01);
        chk({6'h00, drv_b}, (p == 1) ? 8'h03 : 8'h01);
        set_ev(6'h00);
      end
    end
    wr_reg(8'h56, 8'h20);
    wr_reg(8'h58, 8'h04);
    set_ev(6'h20);
    tick(1);
    chk({6'h00, drv_a}, 8'h03);
    set_ev(6'h00);
    wr_reg(8'h58, 8'h00);
    wr_reg(8'h57, 8'h00);
    wr_reg(8'h56, 8'h20);
    wr_reg(8'h53, 8'h08);
    set_ev(6'h01);
    tick(1);
    chk({6'h00, drv_a}, 8'h01);
    chk({7'h00, wire_a}, 8'h00);
    wr_reg(8'h53, 8'h0c);
    set_ev(6'h00);
    tick(1);
    chk({6'h00, drv_a}, 8'h00);
    chk({7'h00, wire_a}, 8'h01);
    set_ev(6'h01);
    tick(1);
    chk({6'h00, drv_a}, 8'h01);
    wr_reg(8'h53, 8'h02);
    tick(1);
    chk({7'h00, drv_a.oe}, 8'h00);
    set_ev(6'h00);
    wr_reg(8'h53, 8'h0a);
    rd_chk(8'h5a, 8'h3f);
    wr_reg(8'h55, 8'h01);
    wr_reg(8'h57, 8'h20);
    set_ev(6'h01);
    set_ev(6'h00);
    tick(3);
    chk({6'h00, drv_a}, 8'h03);
    chk({6'h00, drv_b}, 8'h03);
    chk({7'h00, irq}, 8'h00);
    wr_reg(8'h5b, 8'h01);
    tick(1);
    chk({7'h00, irq}, 8'h01);
    rd_chk(8'h5a, 8'h01);
    tick(1);
    chk({6'h00, drv_a}, 8'h01);
    chk({6'h00, drv_b}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr_reg(8'h55, 8'h00);
    set_ev(6'h01);
    set_ev(6'h00);
    #1;
    chk({6'h00, drv_a}, 8'h03);
    tick(1);
    chk({6'h00, drv_a}, 8'h01);
    wr_reg(8'h53, 8'h13);
    @(posedge i_clock);
    hen_a  <= 1'b1;
    hlvl_a <= 1'b1;
    tick(3);
    chk({7'h00, trig_a}, 8'h01);
    tick(1);
    chk({7'h00, trig_a}, 8'h00);
    wr_reg(8'h53, 8'h12);
    tick(3);
    chk({7'h00, trig_a}, 8'h01);
    tick(3);
    chk({7'h00, trig_a}, 8'h01);
    wr_reg(8'h53, 8'h02);
    tick(3);
    chk({7'h00, trig_a}, 8'h00);
    wr_reg(8'h53, 8'h10);
    tick(3);
    chk({7'h00, trig_a}, 8'h00);
    @(posedge i_clock);
    hlvl_a <= 1'b0;
    tick(3);
    chk({7'h00, trig_a}, 8'h01);
    wr_reg(8'h54, 8'h13);
    @(posedge i_clock);
    hen_b  <= 1'b1;
    hlvl_b <= 1'b1;
    tick(3);
    chk({7'h00, trig_b}, 8'h01);
    complete_run();
  end
endmodule
